// [icc_cache_ctrl.sv]
// instruction cache control: fetch lookup, flash fill, error logs,
// hit and miss counters, flash sleep on a run of hits
// assumes fetch, hub, flash and wake signals are on clk_i
`timescale 1ns/1ps

module icc_cache_ctrl
    import icc_pkg::*;
#(
    parameter int LINES = 16,
    parameter logic [31:0] FLASH_BYTES = 32'h0004_0000
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // instruction fetch port
    input wire logic fetch_req_i,
    input wire logic [31:0] fetch_addr_i,
    output logic fetch_ready_o,
    output logic fetch_valid_o,
    output logic [31:0] fetch_data_o,
    output logic fetch_err_o,
    // peripheral hub flash read port
    input wire logic hub_req_i,
    input wire logic [31:0] hub_addr_i,
    output logic hub_ready_o,
    output logic hub_valid_o,
    output logic [31:0] hub_data_o,
    output logic hub_err_o,
    // flash read port with error status
    output logic flash_req_o,
    output logic [icc_pkg::FLASH_AW-1:0] flash_addr_o,
    input wire logic flash_rvalid_i,
    input wire logic [31:0] flash_rdata_i,
    input wire logic flash_corrected_i,
    input wire logic flash_uncorrectable_i,
    output logic flash_sleep_o,
    // power manager
    input wire logic wake_i,
    // register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [icc_pkg::REG_IDX_W-1:0] reg_idx_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    // corrected-error interrupt
    output logic corr_irq_o
);
    import icc_pkg::*;

    localparam int IDX_W = $clog2(LINES);
    localparam int TAG_W = FLASH_AW - WORD_LSB - IDX_W;

    typedef struct packed {
        icc_state_t state;
        logic [FLASH_AW-1:0] req_addr;
        logic req_hub;
        logic req_alloc;
        logic flash_req;
        logic dis;
        logic [THRESH_W-1:0] thresh;
        logic irq_en;
        logic corr_valid;
        logic [FLASH_AW-1:0] corr_addr;
        logic err_valid;
        logic [FLASH_AW-1:0] err_addr;
        logic [CNT_W-1:0] hits;
        logic [CNT_W-1:0] misses;
        logic [THRESH_W-1:0] seq;
        logic sleep;
        logic fetch_valid;
        logic [31:0] fetch_data;
        logic fetch_err;
        logic hub_valid;
        logic [31:0] hub_data;
        logic hub_err;
        logic irq;
        logic [31:0] rdata;
    } icc_ctrl_t;

    // configuration fields take constants only; nothing resets them on wake
    localparam icc_ctrl_t CTRL_RESET = '{
        state: ICC_ST_IDLE,
        dis: CTL_DISABLE_RESET,
        thresh: CTL_THRESH_RESET,
        default: '0
    };

    logic [1:0] rst_sync;
    logic rst_n;
    icc_ctrl_t r;
    icc_ctrl_t next_r;

    logic look_hit;
    logic [31:0] look_data;
    logic ls_wr;
    logic ls_inv;
    logic flush_all;
    logic ctl_wr;
    logic corr_wr;
    logic hm_wr;

    // true when a byte address lies inside the on-chip flash
    function automatic logic in_flash(input logic [31:0] addr);
        in_flash = addr < FLASH_BYTES;
    endfunction

    function automatic logic [IDX_W-1:0] line_idx(
        input logic [FLASH_AW-1:0] addr);
        line_idx = addr[WORD_LSB +: IDX_W];
    endfunction

    function automatic logic [TAG_W-1:0] line_tag(
        input logic [FLASH_AW-1:0] addr);
        line_tag = addr[FLASH_AW-1 -: TAG_W];
    endfunction

    // reset release is synchronised; assertion stays asynchronous
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    icc_line_store #(
        .LINES(LINES),
        .IDX_W(IDX_W),
        .TAG_W(TAG_W)
    ) u_store (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .look_idx_i(line_idx(fetch_addr_i[FLASH_AW-1:0])),
        .look_tag_i(line_tag(fetch_addr_i[FLASH_AW-1:0])),
        .look_hit_o(look_hit),
        .look_data_o(look_data),
        .wr_i(ls_wr),
        .inv_i(ls_inv),
        .wr_idx_i(line_idx(r.req_addr)),
        .wr_tag_i(line_tag(r.req_addr)),
        .wr_data_i(flash_rdata_i),
        .flush_i(flush_all)
    );

    assign ctl_wr = reg_wr_i && (reg_idx_i == REG_CTL);
    assign corr_wr = reg_wr_i && (reg_idx_i == REG_CORR);
    assign hm_wr = reg_wr_i && (reg_idx_i == REG_HIT_MISS_COUNTERS);
    assign flush_all = (ctl_wr && reg_wdata_i[CTL_FLUSH_BIT]) || wake_i;

    // fetch has priority over the hub when both are waiting in idle
    assign fetch_ready_o = (r.state == ICC_ST_IDLE);
    assign hub_ready_o = (r.state == ICC_ST_IDLE) && !fetch_req_i;

    always_comb begin
        next_r = r;
        ls_wr = 1'b0;
        ls_inv = 1'b0;
        next_r.flash_req = 1'b0;
        next_r.fetch_valid = 1'b0;
        next_r.hub_valid = 1'b0;
        next_r.irq = 1'b0;

        // configuration writes; clears land before events so a set wins
        if (ctl_wr) begin
            next_r.dis = reg_wdata_i[CTL_DISABLE_BIT];
            next_r.thresh = reg_wdata_i[CTL_THRESH_LSB +: THRESH_W];
        end
        if (corr_wr) begin
            next_r.irq_en = reg_wdata_i[CORR_IRQ_EN_BIT];
            if (reg_wdata_i[LOG_VALID_BIT]) begin
                next_r.corr_valid = 1'b0;
            end
        end

        case (r.state)
            ICC_ST_IDLE: begin
                if (fetch_req_i) begin
                    if (!in_flash(fetch_addr_i)) begin
                        // no path beyond flash: answer at once with error
                        next_r.fetch_valid = 1'b1;
                        next_r.fetch_err = 1'b1;
                        next_r.fetch_data = 32'h0000_0000;
                    end else if (!r.dis && look_hit) begin
                        next_r.fetch_valid = 1'b1;
                        next_r.fetch_err = 1'b0;
                        next_r.fetch_data = look_data;
                        next_r.hits = r.hits + 16'h0001;
                        if (r.seq != {THRESH_W{1'b1}}) begin
                            next_r.seq = r.seq + 8'h01;
                        end
                    end else begin
                        next_r.req_addr = fetch_addr_i[FLASH_AW-1:0];
                        next_r.req_hub = 1'b0;
                        next_r.req_alloc = !r.dis;
                        next_r.flash_req = 1'b1;
                        next_r.state = ICC_ST_WAIT;
                        next_r.seq = 8'h00;
                        if (!r.dis) begin
                            next_r.misses = r.misses + 16'h0001;
                        end
                    end
                end else if (hub_req_i) begin
                    next_r.req_addr = hub_addr_i[FLASH_AW-1:0];
                    next_r.req_hub = 1'b1;
                    next_r.req_alloc = 1'b0;
                    next_r.flash_req = 1'b1;
                    next_r.state = ICC_ST_WAIT;
                end
            end
            ICC_ST_WAIT: begin
                // one request per miss; the flash answers within its wait
                if (flash_rvalid_i) begin
                    next_r.state = ICC_ST_IDLE;
                    if (flash_uncorrectable_i) begin
                        next_r.err_valid = 1'b1;
                        next_r.err_addr = r.req_addr;
                        ls_inv = r.req_alloc;
                    end else begin
                        ls_wr = r.req_alloc;
                    end
                    if (flash_corrected_i && !flash_uncorrectable_i) begin
                        next_r.corr_valid = 1'b1;
                        next_r.corr_addr = r.req_addr;
                        next_r.irq = r.irq_en;
                    end
                    if (r.req_hub) begin
                        next_r.hub_valid = 1'b1;
                        next_r.hub_data = flash_rdata_i;
                        next_r.hub_err = flash_uncorrectable_i;
                    end else begin
                        next_r.fetch_valid = 1'b1;
                        next_r.fetch_data = flash_rdata_i;
                        next_r.fetch_err = flash_uncorrectable_i;
                    end
                end
            end
            default: begin
                next_r.state = ICC_ST_IDLE;
            end
        endcase

        // a software write to the counters beats a count in the same cycle
        if (hm_wr) begin
            next_r.hits = reg_wdata_i[HIT_LSB +: CNT_W];
            next_r.misses = reg_wdata_i[MISS_LSB +: CNT_W];
        end

        // flash may sleep only while no read is outstanding
        next_r.sleep = (next_r.state == ICC_ST_IDLE) &&
            ((r.thresh == 8'h00) || (next_r.seq >= r.thresh));

        // read data is registered; reads have no side effects
        next_r.rdata = r.rdata;
        if (reg_rd_i) begin
            case (reg_idx_i)
                REG_CTL: begin
                    next_r.rdata = 32'h0000_0000;
                    next_r.rdata[CTL_DISABLE_BIT] = r.dis;
                    next_r.rdata[CTL_THRESH_LSB +: THRESH_W] = r.thresh;
                end
                REG_CORR: begin
                    next_r.rdata = 32'h0000_0000;
                    next_r.rdata[LOG_ADDR_LSB +: FLASH_AW] = r.corr_addr;
                    next_r.rdata[LOG_VALID_BIT] = r.corr_valid;
                    next_r.rdata[CORR_IRQ_EN_BIT] = r.irq_en;
                end
                REG_ERR: begin
                    next_r.rdata = 32'h0000_0000;
                    next_r.rdata[LOG_ADDR_LSB +: FLASH_AW] = r.err_addr;
                    next_r.rdata[LOG_VALID_BIT] = r.err_valid;
                end
                REG_HIT_MISS_COUNTERS: begin
                    next_r.rdata = {r.hits, r.misses};
                end
                default: begin
                    next_r.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            r <= CTRL_RESET;
        end else begin
            r <= next_r;
        end
    end

    assign fetch_valid_o = r.fetch_valid;
    assign fetch_data_o = r.fetch_data;
    assign fetch_err_o = r.fetch_err;
    assign hub_valid_o = r.hub_valid;
    assign hub_data_o = r.hub_data;
    assign hub_err_o = r.hub_err;
    assign flash_req_o = r.flash_req;
    assign flash_addr_o = r.req_addr;
    assign flash_sleep_o = r.sleep;
    assign reg_rdata_o = r.rdata;
    assign corr_irq_o = r.irq;

endmodule

// [icc_pkg.sv]
// constants, register map and types of the instruction cache control block
// assumes one processor clock domain and a word-wide flash read port
package icc_pkg;

    // flash address space and word geometry
    localparam int FLASH_AW = 29;
    localparam int WORD_W = 32;
    localparam int WORD_LSB = 2;

    // register index on the register port
    localparam int REG_IDX_W = 2;
    localparam logic [1:0] REG_CTL = 2'h0;
    localparam logic [1:0] REG_CORR = 2'h1;
    localparam logic [1:0] REG_ERR = 2'h2;
    localparam logic [1:0] REG_HIT_MISS_COUNTERS = 2'h3;

    // cache_control fields
    localparam int CTL_DISABLE_BIT = 0;
    localparam int CTL_FLUSH_BIT = 2;
    localparam int CTL_THRESH_LSB = 8;
    localparam int THRESH_W = 8;
    localparam logic CTL_DISABLE_RESET = 1'b0;
    localparam logic [7:0] CTL_THRESH_RESET = 8'h00;

    // corrected_error_log and uncorrectable_error_log fields
    localparam int LOG_ADDR_LSB = 0;
    localparam int LOG_VALID_BIT = 29;
    localparam int CORR_IRQ_EN_BIT = 30;

    // hit_miss_counters fields
    localparam int CNT_W = 16;
    localparam int HIT_LSB = 16;
    localparam int MISS_LSB = 0;

    // longest flash read, in processor clocks
    localparam int FLASH_READ_MAX_CYC = 4;

    typedef enum logic [0:0] {
        ICC_ST_IDLE = 1'b0,
        ICC_ST_WAIT = 1'b1
    } icc_state_t;

endpackage

// [icc_line_store.sv]
// direct-mapped line store: valid bits, tags and one data word per line
// assumes a synchronised active-low reset from the instantiating module
`timescale 1ns/1ps

module icc_line_store #(
    parameter int LINES = 16,
    parameter int IDX_W = 4,
    parameter int TAG_W = 23
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // lookup
    input wire logic [IDX_W-1:0] look_idx_i,
    input wire logic [TAG_W-1:0] look_tag_i,
    output logic look_hit_o,
    output logic [31:0] look_data_o,
    // fill and invalidate of one line
    input wire logic wr_i,
    input wire logic inv_i,
    input wire logic [IDX_W-1:0] wr_idx_i,
    input wire logic [TAG_W-1:0] wr_tag_i,
    input wire logic [31:0] wr_data_i,
    // invalidate every line
    input wire logic flush_i
);
    typedef struct packed {
        logic [LINES-1:0] valid;
        logic [LINES-1:0][TAG_W-1:0] tag;
        logic [LINES-1:0][31:0] data;
    } icc_store_t;

    icc_store_t r;
    icc_store_t next_r;

    assign look_hit_o = r.valid[look_idx_i] && (r.tag[look_idx_i] == look_tag_i);
    assign look_data_o = r.data[look_idx_i];

    always_comb begin
        next_r = r;
        if (wr_i) begin
            next_r.valid[wr_idx_i] = 1'b1;
            next_r.tag[wr_idx_i] = wr_tag_i;
            next_r.data[wr_idx_i] = wr_data_i;
        end
        // a failed fill drops the whole line, data untouched
        if (inv_i) begin
            next_r.valid[wr_idx_i] = 1'b0;
        end
        // flush beats a fill landing in the same cycle, so no stale line
        if (flush_i) begin
            next_r.valid = '0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

endmodule

// [icc_monitor.sv]
// port assertions for the instruction cache control block
// assumes binding to icc_cache_ctrl; sees its ports only
`timescale 1ns/1ps

module icc_monitor
    import icc_pkg::*;
#(
    parameter logic [31:0] FLASH_BYTES = 32'h0004_0000
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // watched ports
    input wire logic fetch_req_i,
    input wire logic [31:0] fetch_addr_i,
    input wire logic fetch_ready_o,
    input wire logic fetch_valid_o,
    input wire logic fetch_err_o,
    input wire logic hub_valid_o,
    input wire logic hub_err_o,
    input wire logic flash_req_o,
    input wire logic flash_rvalid_i,
    input wire logic flash_corrected_i,
    input wire logic flash_uncorrectable_i,
    input wire logic flash_sleep_o,
    input wire logic wake_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [REG_IDX_W-1:0] reg_idx_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic corr_irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic take;
    logic fl_in;
    assign take = fetch_req_i && fetch_ready_o;
    assign fl_in = fetch_addr_i < FLASH_BYTES;

    AST_FLUSH_INV: assert property (reg_wr_i && reg_idx_i == REG_CTL &&
        reg_wdata_i[CTL_FLUSH_BIT] ##1 take && fl_in |=> !fetch_valid_o)
        else $error("fetch hit right after flush");
    AST_WAKE_INV: assert property (wake_i ##1 take && fl_in
        |=> !fetch_valid_o) else $error("fetch hit right after wake");
    AST_ONE_READ: assert property (flash_req_o |=> !flash_req_o [*2])
        else $error("flash read repeated");
    AST_FETCH_LAT: assert property (take |-> ##[1:6] fetch_valid_o)
        else $error("fetch not answered in time");
    AST_NON_FLASH: assert property (take && !fl_in |=> fetch_valid_o &&
        fetch_err_o && !flash_req_o) else $error("non-flash fetch");
    AST_UNC_ERR: assert property (flash_rvalid_i && flash_uncorrectable_i
        |=> (fetch_valid_o && fetch_err_o) || (hub_valid_o && hub_err_o))
        else $error("uncorrectable fill without error");
    AST_IRQ_CAUSE: assert property (corr_irq_o |-> $past(flash_rvalid_i &&
        flash_corrected_i && !flash_uncorrectable_i))
        else $error("interrupt without correction");
    AST_HM_CLEAR: assert property (reg_wr_i && reg_idx_i == REG_HIT_MISS_COUNTERS &&
        reg_wdata_i == 32'h0 ##1 reg_rd_i && reg_idx_i == REG_HIT_MISS_COUNTERS
        |=> reg_rdata_o == 32'h0) else $error("counters not cleared");
    // the answer cycle ends the read, so sleep may follow it at once
    AST_SLEEP_BUSY: assert property (!fetch_ready_o && !flash_rvalid_i
        |=> !flash_sleep_o)
        else $error("flash asleep during a read");

    COV_IRQ: cover property (flash_rvalid_i && flash_corrected_i ##1 corr_irq_o);
    COV_HIT: cover property (take && fl_in ##1 fetch_valid_o);
    COV_SLEEP: cover property ($rose(flash_sleep_o));
endmodule

bind icc_cache_ctrl icc_monitor #(.FLASH_BYTES(FLASH_BYTES)) icc_monitor_i (.*);

// [icc_flash_model.sv]
// flash word read port model with error status per read
// assumes one outstanding read at a time
`timescale 1ns/1ps

module icc_flash_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // read request and bench controls
    input wire logic req_i,
    input wire logic [28:0] addr_i,
    input wire logic [1:0] lat_i,
    input wire logic corr_i,
    input wire logic unc_i,
    // answer
    output logic rvalid_o,
    output logic [31:0] rdata_o,
    output logic corrected_o,
    output logic uncorrectable_o
);
    logic [2:0] cnt;
    logic [28:0] a;
    logic [31:0] last;
    logic c;
    logic u;
    assign rvalid_o = cnt == 3'h1;
    // data outside the answer cycle is the inverse of the last word
    assign rdata_o = rvalid_o ? {3'h5, a} : ~last;
    assign corrected_o = rvalid_o & c;
    assign uncorrectable_o = rvalid_o & u;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= 3'h0;
            last <= 32'h0;
        end else if (req_i) begin
            cnt <= {1'b0, lat_i} + 3'h1;
            a <= addr_i;
            c <= corr_i;
            u <= unc_i;
        end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
            if (rvalid_o) last <= rdata_o;
        end
    end
endmodule

// [tb.sv]
// self-checking bench for the instruction cache control block
// assumes the flash model answers every read within four clocks
`timescale 1ns/1ps

module tb;
    import icc_pkg::*;
    logic clk_i = 1'b0, rst_n_i = 1'b0, fetch_req_i = 1'b0, hub_req_i = 1'b0;
    logic [31:0] fetch_addr_i = 32'h0, hub_addr_i = 32'h0;
    logic fetch_ready_o, fetch_valid_o, fetch_err_o, hub_ready_o;
    logic hub_valid_o, hub_err_o, flash_req_o, flash_rvalid_i;
    logic flash_corrected_i, flash_uncorrectable_i, flash_sleep_o;
    logic corr_irq_o, wake_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [31:0] fetch_data_o, hub_data_o, reg_rdata_o, flash_rdata_i;
    logic [31:0] reg_wdata_i = 32'h0;
    logic [FLASH_AW-1:0] flash_addr_o;
    logic [1:0] reg_idx_i = 2'h0, lat = 2'h0;
    logic corr = 1'b0, unc = 1'b0, rd_seen = 1'b0, en = 1'b1;
    logic [15:0] hits = 16'h0, miss = 16'h0;
    logic [3:0] irq_n = 4'h0;
    logic [31:0] ar[8];
    int error_cnt = 0, num_checks = 0;
    logic [33:0] fq[$];
    logic [31:0] rq[$];
    bit cached[bit [31:0]];

    icc_cache_ctrl #(.LINES(16)) icc_cache_ctrl_i (.*);
    icc_flash_model icc_flash_model_i (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .req_i(flash_req_o),
        .addr_i(flash_addr_o),
        .lat_i(lat),
        .corr_i(corr),
        .unc_i(unc),
        .rvalid_o(flash_rvalid_i),
        .rdata_o(flash_rdata_i),
        .corrected_o(flash_corrected_i),
        .uncorrectable_o(flash_uncorrectable_i)
    );

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    task automatic wr(input logic [1:0] i, input logic [31:0] d);
        reg_wr_i = 1'b1;
        reg_idx_i = i;
        reg_wdata_i = d;
        tick(1);
        reg_wr_i = 1'b0;
    endtask

    task automatic rd(input logic [1:0] i, input logic [31:0] e);
        rq.push_back(e);
        reg_rd_i = 1'b1;
        reg_idx_i = i;
        tick(1);
        reg_rd_i = 1'b0;
    endtask

    // expectation first, then the request is held until ready is seen
    task automatic fetch(input logic [31:0] a, input bit h);
        bit inf;
        int k;
        inf = a < 32'h0004_0000;
        fq.push_back({!unc && inf, unc || !inf, 3'h5, a[28:0]});
        if (en && inf && !h) begin
            if (cached.exists(a)) hits++;
            else miss++;
            if (unc) cached.delete(a);
            else cached[a] = 1'b1;
        end
        hub_req_i = h;
        fetch_req_i = !h;
        fetch_addr_i = a;
        hub_addr_i = a;
        for (k = 0; k < 20 && (h ? hub_ready_o : fetch_ready_o) !== 1'b1; k++)
            tick(1);
        tick(1);
        fetch_req_i = 1'b0;
        hub_req_i = 1'b0;
        for (k = 0; k < 20 && fq.size() > 0; k++) tick(1);
        // let the interrupt counter see the pulse before callers look
        tick(1);
        if (k == 20) begin
            error_cnt++;
            test_done();
        end
    endtask

    always @(posedge clk_i) begin
        rd_seen <= reg_rd_i;
        if (corr_irq_o === 1'b1) irq_n <= irq_n + 4'h1;
    end

    always @(negedge clk_i) begin
        logic [33:0] e;
        logic [32:0] g;
        if (fetch_valid_o === 1'b1 || hub_valid_o === 1'b1) begin
            g = fetch_valid_o ? {fetch_err_o, fetch_data_o}
                              : {hub_err_o, hub_data_o};
            e = fq.size() > 0 ? fq.pop_front() : 34'h0;
            // data is not defined on an error answer
            if (!e[33]) g[31:0] = e[31:0];
            chk(g, e[32:0]);
        end
        if (rd_seen) chk(reg_rdata_o, rq.pop_front());
    end

    initial begin
        void'($urandom(32'h518531a0));
        tick(20);
        rst_n_i = 1'b1;
        tick(4);
        chk(flash_sleep_o, 1'b1);
        rd(REG_CTL, 32'h0);
        rd(REG_HIT_MISS_COUNTERS, 32'h0);
        foreach (ar[i]) ar[i] = 32'(($urandom_range(0, 4095) << 6) | (i << 2));
        for (int r = 0; r < 2; r++) begin
            foreach (ar[i]) begin
                lat = 2'($urandom_range(0, 3));
                fetch(ar[i], 1'b0);
            end
        end
        rd(REG_HIT_MISS_COUNTERS, {hits, miss});
        wr(REG_HIT_MISS_COUNTERS, 32'hFFFF_FFFF);
        {hits, miss} = 32'hFFFF_FFFF;
        fetch(ar[0], 1'b0);
        rd(REG_HIT_MISS_COUNTERS, {hits, miss});
        wr(REG_HIT_MISS_COUNTERS, 32'h0);
        rd(REG_HIT_MISS_COUNTERS, 32'h0);
        {hits, miss} = 32'h0;
        wr(REG_CTL, 32'h4);
        cached.delete();
        fetch(ar[1], 1'b0);
        rd(REG_CTL, 32'h0);
        rd(REG_HIT_MISS_COUNTERS, {hits, miss});
        wr(REG_CTL, 32'h1);
        en = 1'b0;
        fetch(ar[1], 1'b0);
        fetch(ar[2], 1'b0);
        rd(REG_HIT_MISS_COUNTERS, {hits, miss});
        en = 1'b1;
        wr(REG_CTL, 32'h0000_0200);
        fetch(ar[1], 1'b0);
        fetch(ar[1], 1'b0);
        tick(2);
        chk(flash_sleep_o, 1'b1);
        fetch(ar[3], 1'b0);
        fetch(ar[3], 1'b0);
        tick(2);
        chk(flash_sleep_o, 1'b0);
        wake_i = 1'b1;
        tick(1);
        wake_i = 1'b0;
        cached.delete();
        rd(REG_CTL, 32'h0000_0200);
        fetch(ar[3], 1'b0);
        rd(REG_HIT_MISS_COUNTERS, {hits, miss});
        wr(REG_CORR, 32'h4000_0000);
        corr = 1'b1;
        fetch(ar[4], 1'b0);
        chk(irq_n, 4'h1);
        rd(REG_CORR, 32'h6000_0000 | ar[4]);
        wr(REG_CORR, 32'h2000_0000);
        fetch(ar[5], 1'b0);
        corr = 1'b0;
        chk(irq_n, 4'h1);
        unc = 1'b1;
        fetch(ar[6], 1'b0);
        unc = 1'b0;
        fetch(ar[6], 1'b0);
        rd(REG_ERR, 32'h2000_0000 | ar[6]);
        fetch(ar[7], 1'b1);
        fetch(ar[7], 1'b0);
        rd(REG_HIT_MISS_COUNTERS, {hits, miss});
        fetch(32'h2000_0000, 1'b0);
        tick(2);
        test_done();
    end
endmodule
